// ===== half_bridge_timing_mode_regs_tb.sv
// Testbench of the half-bridge timing and state registers
`timescale 1ns/10ps
`default_nettype none
module half_bridge_timing_mode_regs_tb import hbtm_pkg::*;;
    // ----
    // Signals
    // ----
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             reg_wr = 1'b0;
    logic             reg_rd = 1'b0;
    logic             bank = 1'b0;
    logic [4:0]       addr = 5'h00;
    logic [15:0]      wdat = 16'h0000;
    logic [15:0]      rdat;
    logic [7:0]       hs;
    logic [7:0]       ls;
    logic [7:0]       shoot;
    logic [8*CYC_W-1:0] acc, acb, fwc, fwb;
    int               err_total = 0;
    int               checks_done = 0;
    int ccp_c [8] = '{15, 25, 40, 60, 80, 120, 160, 640};
    int blk_c [8] = '{25, 40, 50, 60, 80, 120, 160, 640};

    always #12.5 clk = ~clk;

    hbtm_regs i_dut (.MCLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_BANK_I(bank), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdat), .REG_RDATA_O(rdat), .HS_ON_O(hs), .LS_ON_O(ls),
        .ACT_CCP_CYC_O(acc), .ACT_BLK_CYC_O(acb), .FW_CCP_CYC_O(fwc),
        .FW_BLK_CYC_O(fwb));
    hbtm_bridge_model i_bridges (.clk_i(clk), .hs_on_i(hs), .ls_on_i(ls),
        .shoot_o(shoot));

    // ----
    // Helpers
    // ----
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic b, input logic [4:0] a,
                      input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        bank <= b;
        addr <= a;
        wdat <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic b, input logic [4:0] a,
                      output logic [15:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        bank <= b;
        addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = rdat;
    endtask
    // Outputs follow one edge after the write edge
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic chk_hb(input int i, input int ac, ab, fc, fb);
        chk({6'h00, acc[10*i +: 10]}, 16'(ac));
        chk({6'h00, acb[10*i +: 10]}, 16'(ab));
        chk({6'h00, fwc[10*i +: 10]}, 16'(fc));
        chk({6'h00, fwb[10*i +: 10]}, 16'(fb));
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_defaults();
        logic [15:0] v;
        rd(1'b0, OFS_TIMING, v);
        chk(v, 16'h4924);
        rd(1'b1, OFS_TIMING, v);
        chk(v, 16'h4924);
        rd(1'b0, OFS_STATE, v);
        chk(v, 16'h0000);
        chk({hs, ls}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            chk_hb(i, 80, 80, 80, 80);
        end
        $display("test defaults done");
    endtask
    task automatic t_reserved();
        logic [15:0] v;
        wr(1'b1, OFS_TIMING, 16'hFFFF);
        rd(1'b1, OFS_TIMING, v);
        chk(v, 16'h7FFF);
        rd(1'b0, OFS_TIMING, v);
        chk(v, 16'h4924);
        wr(1'b0, 5'h1F, 16'hFFFF);
        rd(1'b0, 5'h1F, v);
        chk(v, 16'h0000);
        wr(1'b1, OFS_TIMING, 16'h4924);
        $display("test reserved done");
    endtask
    // Code 7 is used with drive current kept low by the host
    task automatic t_decode();
        int c;
        int l;
        for (int b = 0; b < 2; b++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                wr(b[0], OFS_TIMING, 16'(16'h1249 * k));
                settle();
                c = ccp_c[k];
                l = blk_c[k];
                if (b == 0)
                begin
                    chk_hb(0, c, l, 80, 80);
                end
                else
                begin
                    chk_hb(0, 80, 80, c, l);
                end
            end
            wr(b[0], OFS_TIMING, 16'h4924);
        end
        $display("test decode done");
    endtask
    task automatic t_map();
        logic [15:0] v;
        int ec [4] = '{15, 40, 120, 640};
        int eb [4] = '{40, 60, 160, 25};
        int fc [4] = '{80, 80, 80, 15};
        int fb [4] = '{80, 80, 25, 640};
        wr(1'b0, OFS_TIMING, 16'h5688);
        wr(1'b0, OFS_FOURTH, 16'hFE3E);
        wr(1'b1, OFS_FOURTH, 16'h01C0);
        wr(1'b0, OFS_MAP, 16'h00E4);
        settle();
        rd(1'b0, OFS_FOURTH, v);
        chk(v, 16'h003E);
        rd(1'b1, OFS_FOURTH, v);
        chk(v, 16'h01C0);
        for (int i = 0; i < 4; i++)
        begin
            chk_hb(i, ec[i], eb[i], fc[i], fb[i]);
        end
        chk_hb(4, 15, 40, 80, 80);
        $display("test map done");
    endtask
    task automatic t_mode();
        logic [15:0] v;
        wr(1'b0, OFS_STATE, 16'h1BE4);
        settle();
        rd(1'b0, OFS_STATE, v);
        chk(v, 16'h1BE4);
        chk({hs, ls}, 16'h2442);
        chk({8'h00, shoot}, 16'h0000);
        wr(1'b0, OFS_STATE, 16'hAAAA);
        settle();
        chk({hs, ls}, 16'hFF00);
        // Reserved code on the last bridge, low side on the first
        wr(1'b0, OFS_STATE, 16'hC001);
        settle();
        chk({hs, ls}, 16'h0001);
        $display("test mode done");
    endtask
    task automatic t_rerun();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        $display("test rerun done");
    endtask

    // ----
    // Run
    // ----
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #(25 * 5000);
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_reserved();
        t_decode();
        t_map();
        t_mode();
        t_rerun();
        complete_run();
    end
endmodule // half_bridge_timing_mode_regs_tb
`default_nettype wire

// ===== hbtm_bridge_model.sv
// Model of the external half-bridge power stages
`timescale 1ns/10ps
`default_nettype none
module hbtm_bridge_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] hs_on_i,
    input  wire logic [7:0] ls_on_i,
    output logic      [7:0] shoot_o
);
    // ----
    // Stage
    // ----
    // Both switches on shorts the supply, so it is flagged
    always_ff @(posedge clk_i)
    begin
        shoot_o <= hs_on_i & ls_on_i;
    end
endmodule // hbtm_bridge_model
`default_nettype wire

// ===== hbtm_decode.sv
// Time code to cycle count decoder
`timescale 1ns/10ps
`default_nettype none
module hbtm_decode
    import hbtm_pkg::*;
(
    input  wire logic [2:0]       code_i,
    input  wire logic             is_blank_i,
    output logic      [CYC_W-1:0] cyc_o
);
    // ------------------------------------------------------------------------
    // Table lookup
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (is_blank_i)
        begin
            cyc_o = ns2cyc(BLK_NS[code_i]);
        end
        else
        begin
            cyc_o = ns2cyc(CCP_NS[code_i]);
        end
    end
endmodule // hbtm_decode
`default_nettype wire

// ===== hbtm_pkg.sv
// Package with register map, field layout and timing constants
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
package hbtm_pkg;
    localparam int          CLK_MHZ       = 40;
    localparam logic [4:0]  OFS_TIMING    = 5'h05;
    localparam logic [4:0]  OFS_STATE     = 5'h06;
    localparam logic [4:0]  OFS_MAP       = 5'h04;
    localparam logic [4:0]  OFS_FOURTH    = 5'h0A;
    localparam logic [15:0] RST_TIMING    = 16'h4924;
    localparam logic [15:0] RST_STATE     = 16'h0000;
    localparam logic [15:0] RST_MAP       = 16'h0000;
    localparam logic [15:0] RST_FOURTH    = 16'h0924;
    localparam logic [15:0] TIMING_MASK   = 16'h7FFF;
    localparam int          FLD_W         = 3;
    localparam int          NUM_HB        = 8;
    localparam logic [1:0]  ST_HIZ        = 2'h0;
    localparam logic [1:0]  ST_LS         = 2'h1;
    localparam logic [1:0]  ST_HS         = 2'h2;
    // Typical times in ns, indexed by code
    localparam int CCP_NS [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000,
                                  16000};
    localparam int BLK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000,
                                  16000};
    localparam int CYC_W = 10;
    // Cycles, longest-time style: round down, at least one
    function automatic logic [CYC_W-1:0] ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        if (c < 1)
        begin
            c = 1;
        end
        return c[CYC_W-1:0];
    endfunction
endpackage : hbtm_pkg
`default_nettype wire

// ===== hbtm_regs.sv
// Half-bridge timing and state register bank
`timescale 1ns/10ps
`default_nettype none
module hbtm_regs
    import hbtm_pkg::*;
(
    input  wire logic              MCLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    input  wire logic              REG_BANK_I,
    input  wire logic [4:0]        REG_ADDR_I,
    input  wire logic [15:0]       REG_WDATA_I,
    output logic      [15:0]       REG_RDATA_O,
    output logic      [7:0]        HS_ON_O,
    output logic      [7:0]        LS_ON_O,
    output logic      [8*CYC_W-1:0] ACT_CCP_CYC_O,
    output logic      [8*CYC_W-1:0] ACT_BLK_CYC_O,
    output logic      [8*CYC_W-1:0] FW_CCP_CYC_O,
    output logic      [8*CYC_W-1:0] FW_BLK_CYC_O
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]        act;
        logic [15:0]        fw;
        logic [15:0]        state;
        logic [15:0]        map;
        logic [15:0]        act4;
        logic [15:0]        fw4;
        logic [15:0]        rdata;
        logic [7:0]         hs;
        logic [7:0]         ls;
        logic [8*CYC_W-1:0] accp;
        logic [8*CYC_W-1:0] ablk;
        logic [8*CYC_W-1:0] fccp;
        logic [8*CYC_W-1:0] fblk;
    } hbtm_state_s;

    hbtm_state_s st_r;
    hbtm_state_s st_nxt;

    // Code selected per bridge for each of the four timing slots
    logic [8*FLD_W-1:0] sel_accp;
    logic [8*FLD_W-1:0] sel_ablk;
    logic [8*FLD_W-1:0] sel_fccp;
    logic [8*FLD_W-1:0] sel_fblk;
    logic [8*CYC_W-1:0] dec_accp;
    logic [8*CYC_W-1:0] dec_ablk;
    logic [8*CYC_W-1:0] dec_fccp;
    logic [8*CYC_W-1:0] dec_fblk;

    // ------------------------------------------------------------------------
    // Per-bridge pair selection and decode
    // ------------------------------------------------------------------------
    // Pair four and blank three live in a separate register
    function automatic logic [5:0] pick(input logic [15:0] r2,
                                        input logic [15:0] r3,
                                        input logic [1:0]  p);
        logic [5:0] v;
        v = 6'h00;
        case (p)
            2'h0: v = {r2[5:3], r2[2:0]};
            2'h1: v = {r2[11:9], r2[8:6]};
            2'h2: v = {r3[2:0], r2[14:12]};
            2'h3: v = {r3[8:6], r3[5:3]};
            default: v = 6'h00;
        endcase
        return v;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_HB; g++)
        begin : g_hb
            logic [1:0] p;
            logic [5:0] a;
            logic [5:0] f;
            assign p = st_r.map[2*g +: 2];
            assign a = pick(st_r.act, st_r.act4, p);
            assign f = pick(st_r.fw, st_r.fw4, p);
            assign sel_accp[FLD_W*g +: FLD_W] = a[2:0];
            assign sel_ablk[FLD_W*g +: FLD_W] = a[5:3];
            assign sel_fccp[FLD_W*g +: FLD_W] = f[2:0];
            assign sel_fblk[FLD_W*g +: FLD_W] = f[5:3];
            hbtm_decode u_accp (
                .code_i     (sel_accp[FLD_W*g +: FLD_W]),
                .is_blank_i (1'b0),
                .cyc_o      (dec_accp[CYC_W*g +: CYC_W])
            );
            hbtm_decode u_ablk (
                .code_i     (sel_ablk[FLD_W*g +: FLD_W]),
                .is_blank_i (1'b1),
                .cyc_o      (dec_ablk[CYC_W*g +: CYC_W])
            );
            hbtm_decode u_fccp (
                .code_i     (sel_fccp[FLD_W*g +: FLD_W]),
                .is_blank_i (1'b0),
                .cyc_o      (dec_fccp[CYC_W*g +: CYC_W])
            );
            hbtm_decode u_fblk (
                .code_i     (sel_fblk[FLD_W*g +: FLD_W]),
                .is_blank_i (1'b1),
                .cyc_o      (dec_fblk[CYC_W*g +: CYC_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                OFS_TIMING:
                begin
                    // Bank picks which set sits at the shared offset
                    if (REG_BANK_I)
                    begin
                        st_nxt.fw = REG_WDATA_I & TIMING_MASK;
                    end
                    else
                    begin
                        st_nxt.act = REG_WDATA_I & TIMING_MASK;
                    end
                end
                OFS_STATE:  st_nxt.state = REG_WDATA_I;
                OFS_MAP:    st_nxt.map = REG_WDATA_I;
                OFS_FOURTH:
                begin
                    if (REG_BANK_I)
                    begin
                        st_nxt.fw4 = REG_WDATA_I & 16'h01FF;
                    end
                    else
                    begin
                        st_nxt.act4 = REG_WDATA_I & 16'h01FF;
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                OFS_TIMING: st_nxt.rdata = REG_BANK_I ? st_r.fw
                                                      : st_r.act;
                OFS_STATE:  st_nxt.rdata = st_r.state;
                OFS_MAP:    st_nxt.rdata = st_r.map;
                OFS_FOURTH: st_nxt.rdata = REG_BANK_I ? st_r.fw4 : st_r.act4;
                default:    st_nxt.rdata = 16'h0000;
            endcase
        end
        for (int i = 0; i < NUM_HB; i++)
        begin
            // Code 11 falls to high impedance like 00
            st_nxt.hs[i] = (st_r.state[2*i +: 2] == ST_HS);
            st_nxt.ls[i] = (st_r.state[2*i +: 2] == ST_LS);
        end
        st_nxt.accp = dec_accp;
        st_nxt.ablk = dec_ablk;
        st_nxt.fccp = dec_fccp;
        st_nxt.fblk = dec_fblk;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
        begin
            st_r       <= '0;
            st_r.act   <= RST_TIMING;
            st_r.fw    <= RST_TIMING;
            st_r.state <= RST_STATE;
            st_r.map   <= RST_MAP;
            st_r.act4  <= RST_FOURTH;
            st_r.fw4   <= RST_FOURTH;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA_O   = st_r.rdata;
    assign HS_ON_O       = st_r.hs;
    assign LS_ON_O       = st_r.ls;
    assign ACT_CCP_CYC_O = st_r.accp;
    assign ACT_BLK_CYC_O = st_r.ablk;
    assign FW_CCP_CYC_O  = st_r.fccp;
    assign FW_BLK_CYC_O  = st_r.fblk;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_fw_wr;
        REG_WR_I && REG_BANK_I && REG_ADDR_I == OFS_TIMING;
    endsequence

    // Mode write lands in the register, outputs follow one edge later
    sequence s_state_wr;
        REG_WR_I && REG_ADDR_I == OFS_STATE;
    endsequence

    fw_bank_wr_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        s_fw_wr |=> st_r.fw == ($past(REG_WDATA_I) & TIMING_MASK))
        else $error("freewheel write lost");
    act_bank_keep_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        s_fw_wr |=> st_r.act == $past(st_r.act))
        else $error("active set changed by bank one write");
    reserved_zero_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        REG_RD_I && REG_ADDR_I == OFS_TIMING |=> !REG_RDATA_O[15])
        else $error("reserved bit reads one");
    state_hs_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        s_state_wr ##0 REG_WDATA_I[1:0] == 2'h2
        |=> ##1 HS_ON_O[0] && !LS_ON_O[0])
        else $error("high side not on");
    state_rsv_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        s_state_wr ##0 REG_WDATA_I[15:14] == 2'h3
        |=> ##1 !HS_ON_O[7] && !LS_ON_O[7])
        else $error("reserved code drives bridge");
    reset_hiz_a: assert property (
        @(posedge MCLK_I)
        SYS_RST_I |=> HS_ON_O == 8'h00 && LS_ON_O == 8'h00)
        else $error("bridge not high impedance after reset");
    reset_fw_a: assert property (
        @(posedge MCLK_I)
        SYS_RST_I |=> st_r.fw == RST_TIMING)
        else $error("freewheel default wrong");
    map_pair1_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        st_r.map[1:0] == 2'h0 && $stable(st_r.map) && $stable(st_r.act)
        |=> ACT_BLK_CYC_O[CYC_W-1:0] == ns2cyc(BLK_NS[$past(st_r.act[5:3])]))
        else $error("pair one blank not applied");
    code0_ccp_a: assert property (
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        sel_accp[2:0] == 3'h0 |=> ACT_CCP_CYC_O[CYC_W-1:0] == 10'h00F)
        else $error("375 ns count wrong");
endmodule // hbtm_regs
`default_nettype wire
